// File: bench/crs_core_regs_tb.sv
// Purpose: Self-checking bench for the core register state block.
// Assumes: One bus strobe or operation per task call; warm level held across its reset.
// Notes: Expected values come from integer arithmetic in the bench.
`timescale 1ns/1ns
`default_nettype none
module crs_core_regs_tb import crs_pkg::*;;
  logic        clk;
  logic        rst_b;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  crs_op_t     op;
  logic [3:0]  op_reg;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] pair;
  logic        st_wr;
  logic [31:0] st_addr;
  logic        step_t;
  logic        ill_t;
  logic        bad_t;
  logic [31:0] d;
  logic        warm;
  logic        irq;
  logic [7:0]  vec;
  logic        st_rd;
  logic [31:0] st_wdata;
  logic [15:0] st_psw;
  logic [31:0] h_addr;
  logic [23:0] pc_o;
  logic [15:0] psw_o;
  logic        irq_en;
  int          fails;
  int          n_compared;
  int          a;
  int          b;
  int          s;
  int          e;

  crs_core_regs i_dut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .WARM_RESET_IN(warm), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .OP_CODE_IN(op), .OP_REG_IN(op_reg), .OP_A_IN(op_a), .OP_B_IN(op_b),
    .OP_IRQ_IN(irq), .OP_VECTOR_IN(vec), .PAIR_DATA_OUT(pair),
    .STACK_WR_OUT(st_wr), .STACK_RD_OUT(st_rd), .STACK_ADDR_OUT(st_addr),
    .STACK_WDATA_OUT(st_wdata), .STACK_PSW_OUT(st_psw), .HANDLER_ADDR_OUT(h_addr),
    .PC_OUT(pc_o), .PSW_OUT(psw_o), .IRQ_ENABLE_OUT(irq_en), .STEP_TRAP_OUT(step_t),
    .ILLEGAL_OP_TRAP_OUT(ill_t), .BAD_ADDRESS_TRAP_OUT(bad_t));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [4:0] ad, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [4:0] ad, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Issues one operation; returns one step after the edge that took it.
  task automatic dop(input crs_op_t o, input logic [3:0] r, input logic [31:0] x, y);
    @(posedge clk);
    op <= o;
    op_reg <= r;
    op_a <= x;
    op_b <= y;
    @(posedge clk);
    op <= OP_NOP;
    #1;
  endtask

  task automatic finish_test;
    $display("fails=%0d n_compared=%0d", fails, n_compared);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial
  begin
    {rst_b, warm, irq, vec, addr, wdata, wr, rd, op_reg, op_a, op_b} = '0;
    op = OP_NOP;
    fails = 0;
    n_compared = 0;
    void'($urandom(36));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rreg(5'h14, d);
    chk(d, 32'h0200);
    chk(32'(psw_o), 32'h0200);
    rreg(5'h10, d);
    chk(d, 32'h0);
    wreg(5'h10, 32'h123);
    rreg(5'h10, d);
    chk(d, 32'h122);
    wreg(5'h11, 32'hffff_ffff);
    rreg(5'h11, d);
    chk(d, 32'h00ff_fffe);
    wreg(5'h14, 32'h0fff);
    rreg(5'h14, d);
    chk(d, 32'h0ee7);
    for (int i = 0; i < 6; i++)
    begin
      a = $urandom_range(16'hffff, 0);
      b = $urandom_range(16'hffff, 0);
      s = (i % 2) ? b - a : a + b;
      s = s & 32'h1ffff;
      e = ((i % 2) ? (b < a) : (s >> 16)) | 0;
      s = ((b ^ 32768) - 32768) + ((i % 2) ? -((a ^ 32768) - 32768) : ((a ^ 32768) - 32768));
      e = e | (((s > 32767) || (s < -32768)) << 5);
      dop((i % 2) ? OP_SUB : OP_ADD, 4'h3, a, b);
      rreg(5'h03, d);
      chk(d, 32'(s) & 32'hffff);
      rreg(5'h14, d);
      chk(d & 32'h21, 32'(e));
    end
    for (int i = 0; i < 3; i++)
    begin
      a = $urandom_range(16'hffff, 0);
      b = (i == 2) ? a : $urandom_range(16'hffff, 0);
      e = ((b < a) << 2) | ((a == b) << 6) | ((((b ^ 32768) - 32768) < ((a ^ 32768) - 32768)) << 7);
      dop(OP_CMP, 4'h0, a, b);
      rreg(5'h14, d);
      chk(d & 32'hc4, 32'(e));
    end
    wreg(5'h04, 32'h1234);
    a = $urandom;
    dop(OP_WR_BYTE, 4'h4, a, 32'h0);
    rreg(5'h04, d);
    chk(d, 32'h1200 | (32'(a) & 32'hff));
    wreg(5'h0d, 32'h1111_2222);
    wreg(5'h0e, 32'h3333_4444);
    for (int i = 0; i < 2; i++)
    begin
      wreg(5'h15, i ? 32'h200 : 32'h0);
      dop(OP_RD_PAIR, 4'hd, 32'h0, 32'h0);
      chk(pair, i ? 32'h4444_2222 : 32'h1111_2222);
    end
    wreg(5'h0f, 32'h1000);
    dop(OP_PUSH, 4'h0, 32'h5a5a, 32'h0);
    chk({st_wr, st_addr[30:0]}, 32'h8000_0ffe);
    chk(st_wdata, 32'h0000_5a5a);
    wreg(5'h14, 32'h0a02);
    dop(OP_INSTR_START, 4'h0, 32'h0, 32'h0);
    dop(OP_INSTR_END, 4'h0, 32'h0, 32'h0);
    chk(32'(step_t), 32'h1);
    chk(32'(irq_en), 32'h1);
    wreg(5'h12, 32'h0100_0000);
    wreg(5'h11, 32'h2000);
    wreg(5'h13, 32'h0000_0100);
    dop(OP_ENTER_USER, 4'h0, 32'h400, 32'h0);
    rreg(5'h10, d);
    chk(d, 32'h400);
    chk(32'(pc_o), 32'h400);
    dop(OP_LOAD_USP, 4'h0, 32'h0, 32'h0);
    chk(32'(ill_t), 32'h1);
    dop(OP_PUSH, 4'h0, 32'h1, 32'h0);
    chk(32'({st_wr, bad_t}), 32'h1);
    @(posedge clk);
    irq <= 1'b1;
    vec <= 8'h05;
    dop(OP_EXC_TAKE, 4'h0, 32'h0, 32'h0);
    chk(st_addr, 32'h1ff8);
    chk(st_wdata, 32'h0000_0400);
    chk(32'(st_psw), 32'h0e0a);
    chk(h_addr, 32'h0000_0114);
    rreg(5'h14, d);
    chk(d & 32'h808, 32'h0);
    chk(32'(irq_en), 32'h0);
    dop(OP_INSTR_START, 4'h0, 32'h0, 32'h0);
    dop(OP_INSTR_END, 4'h0, 32'h0, 32'h0);
    chk(32'(step_t), 32'h0);
    dop(OP_EXC_RET, 4'h0, 32'h0, 32'h0202);
    chk({st_rd, st_addr[30:0]}, 32'h8000_1ff8);
    rreg(5'h14, d);
    chk(d, 32'h0a02);
    chk(32'(psw_o), 32'h0a02);
    rreg(5'h11, d);
    chk(d, 32'h2000);
    wreg(5'h10, 32'h00ab_cdef);
    @(posedge clk);
    warm <= 1'b1;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    warm <= 1'b0;
    rreg(5'h00, d);
    chk(d, 32'h0000_cdee);
    rreg(5'h01, d);
    chk(d, 32'h0000_00ab);
    rreg(5'h02, d);
    chk(d, 32'h0000_0a02);
    rreg(5'h10, d);
    chk(d, 32'h0);
    rreg(5'h14, d);
    chk(d, 32'h0200);
    finish_test();
  end
endmodule
`default_nettype wire

// File: pkg/crs_defs.svh
// Purpose: Constants for the core register state block: map, fields, resets.
// Assumes: Register port addresses are word indices, 32-bit data.
// Notes: Types live in crs_pkg; this header holds only macros.
// Operation
// - R0-R11, status, config 16 bits; rest 32.
// - Program counter 24 bits, bit zero reads zero.
// - Reserved bits written zero, read undefined.
// - Short pairing follows older consecutive register grouping.
// - Native pairing stops at R11; R12-R15 are 32-bit.
// - Byte operation touches only low byte.
// - Word operation on pair touches lower word.
// - Reset loads PC preset; warm reset saves PC.
// - Exception stack pointer bit zero, top byte zero.
// - Exceptions push frame down, returns pop it.
// - User stack above 24-bit space raises bad address.
// - Status word field layout; bits 4, 8 zero.
// - Carry set on add carry or subtract borrow.
// - Trace traps every instruction, not inside handlers.
// - Low flag: unsigned second below first.
// - Stack uses supervisor or user pointer by mode.
// - Taking exception forces supervisor mode.
// - User mode entered only by user jump; the code also enters it when an exception return restores the user bit.
// - User stack pointer access in user mode traps.
// - Add and subtract report overflow in flag.
// - Compare sets zero flag on equal operands.
// - Negative flag: signed second below first.
// - Reset clears status except local enable set.
// - Interrupts need both enables; global auto-managed.
// - Trace copied to pending; trap if pending.
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH
`define CRS_ADDR_GPR_LAST 5'h0f
`define CRS_ADDR_PC       5'h10
`define CRS_ADDR_ESP      5'h11
`define CRS_ADDR_USP      5'h12
`define CRS_ADDR_ETB      5'h13
`define CRS_ADDR_PSW      5'h14
`define CRS_ADDR_CFG      5'h15
`define CRS_PSW_C 0
`define CRS_PSW_T 1
`define CRS_PSW_L 2
`define CRS_PSW_U 3
`define CRS_PSW_F 5
`define CRS_PSW_Z 6
`define CRS_PSW_N 7
`define CRS_PSW_E 9
`define CRS_PSW_P 10
`define CRS_PSW_I 11
`define CRS_PSW_MASK      16'h0eef
`define CRS_PSW_RESET     16'h0200
`define CRS_CFG_SR        9
`define CRS_CFG_MASK      16'h0200
`define CRS_ESP_MASK      32'h00ff_fffe
`define CRS_USP_LIMIT     32'h00ff_ffff
`define CRS_PC_EVEN_MASK  24'hff_fffe
`define CRS_FRAME_BYTES   32'h0000_0008
`define CRS_WORD_BYTES    32'h0000_0002
`define CRS_FIRST_WIDE    4'hc
`define CRS_LAST_NARROW   4'hb
`define CRS_LAST_SHORT    4'hd
`define CRS_SSP_HI        2'h3
`define CRS_SSP_LO        4'hf
`define CRS_DEPTH_MAX     4'hf
`endif

// File: pkg/crs_pkg.sv
// Purpose: Types shared by the core register state block.
// Assumes: Operation codes are issued by the core's sequencer, one per cycle.
// Notes: Operand A is the first operand, operand B the second.
`default_nettype none
package crs_pkg;
  typedef enum logic [3:0] {
    OP_NOP         = 4'h0,
    OP_INSTR_START = 4'h1,
    OP_INSTR_END   = 4'h2,
    OP_ADD         = 4'h3,
    OP_SUB         = 4'h4,
    OP_CMP         = 4'h5,
    OP_WR_BYTE     = 4'h6,
    OP_WR_WORD     = 4'h7,
    OP_WR_PAIR     = 4'h8,
    OP_RD_PAIR     = 4'h9,
    OP_PUSH        = 4'ha,
    OP_POP         = 4'hb,
    OP_EXC_TAKE    = 4'hc,
    OP_EXC_RET     = 4'hd,
    OP_ENTER_USER  = 4'he,
    OP_LOAD_USP    = 4'hf
  } crs_op_t;
endpackage
`default_nettype wire

// File: rtl/crs_core_regs.sv
// Purpose: Architectural register state, status word, stacks and traps of the core.
// Assumes: One operation per cycle on OP_CODE_IN; register port never waits.
// Notes: General registers, warm shadows and warm synchroniser carry no reset; other control state does.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "crs_defs.svh"
module crs_core_regs
  import crs_pkg::*;
#(
  parameter logic [23:0] PC_PRESET = 24'h00_0000
)
(
  input  wire logic        CLK_IN,              // Core clock, 125 MHz.
  input  wire logic        RST_B_IN,            // Asynchronous reset, active low.
  input  wire logic        WARM_RESET_IN,       // High across a reset that is warm.
  input  wire logic [4:0]  REG_ADDR_IN,         // Register word index.
  input  wire logic [31:0] REG_WDATA_IN,        // Register write data.
  input  wire logic        REG_WR_IN,           // Register write strobe.
  input  wire logic        REG_RD_IN,           // Register read strobe.
  output logic      [31:0] REG_RDATA_OUT,       // Read data, cycle after strobe.
  input  wire crs_op_t     OP_CODE_IN,          // Operation from the sequencer.
  input  wire logic [3:0]  OP_REG_IN,           // General register operand.
  input  wire logic [31:0] OP_A_IN,             // First operand.
  input  wire logic [31:0] OP_B_IN,             // Second operand.
  input  wire logic        OP_IRQ_IN,           // Exception is a maskable interrupt.
  input  wire logic [7:0]  OP_VECTOR_IN,        // Exception table entry.
  output logic      [31:0] PAIR_DATA_OUT,       // Pair read result.
  output logic             STACK_WR_OUT,        // Stack store pulse.
  output logic             STACK_RD_OUT,        // Stack load pulse.
  output logic      [31:0] STACK_ADDR_OUT,      // Stack access address.
  output logic      [31:0] STACK_WDATA_OUT,     // Stack store data.
  output logic      [15:0] STACK_PSW_OUT,       // Status word saved in a frame.
  output logic      [31:0] HANDLER_ADDR_OUT,    // Table entry address of handler.
  output logic      [23:0] PC_OUT,              // Program counter.
  output logic      [15:0] PSW_OUT,             // Status word.
  output logic             IRQ_ENABLE_OUT,      // Maskable interrupts accepted.
  output logic             STEP_TRAP_OUT,       // Trace trap pulse.
  output logic             ILLEGAL_OP_TRAP_OUT, // Privileged access trap pulse.
  output logic             BAD_ADDRESS_TRAP_OUT // Bad stack address trap pulse.
);

  if (PC_PRESET[0] != 1'b0)
  begin : g_preset_check
    $error("PC_PRESET must be even");
  end

  logic        rst_meta_reg;
  logic        rst_n;
  logic        warm_meta_reg;
  logic        warm_sync_reg;
  logic        boot_reg;
  logic [15:0] gpr_lo_reg [16];
  logic [15:0] gpr_hi_reg [4];
  logic [23:0] pc_reg;
  logic [23:0] pc_shadow_reg;
  logic [15:0] psw_shadow_reg;
  logic [31:0] esp_reg;
  logic [31:0] usp_reg;
  logic [31:0] etb_reg;
  logic [15:0] psw_reg;
  logic [15:0] cfg_reg;
  logic [3:0]  depth_reg;
  logic        user;
  logic        short_pairs;
  logic        in_handler;
  logic        bus_wr;
  logic        stack_op;
  logic        stack_bad;
  logic        usp_illegal;
  logic [31:0] sp_cur;
  logic [31:0] push_addr;
  logic [15:0] opa16;
  logic [15:0] opb16;
  logic        is_sub;
  logic [16:0] sum17;
  logic        ovf;

  // Full view of a general register; R12 to R15 carry an upper word.
  function automatic logic [31:0] reg_full(input logic [3:0] idx);
    logic [31:0] v;
    v = {16'h0000, gpr_lo_reg[idx]};
    if (idx >= `CRS_FIRST_WIDE)
    begin
      v[31:16] = gpr_hi_reg[idx[1:0]];
    end
    return v;
  endfunction

  // Pair view: {upper, lower} word of the pair that starts at idx.
  function automatic logic [31:0] pair_read(input logic [3:0] idx, input logic short_sel);
    logic [31:0] v;
    v = reg_full(idx);
    if (idx <= `CRS_LAST_NARROW || (short_sel && idx <= `CRS_LAST_SHORT))
    begin
      v = {gpr_lo_reg[idx + 4'h1], gpr_lo_reg[idx]};
    end
    return v;
  endfunction

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // The warm level must survive the reset, so this synchroniser is not reset.
  always_ff @(posedge CLK_IN)
  begin
    warm_meta_reg <= WARM_RESET_IN;
    warm_sync_reg <= warm_meta_reg;
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_reg <= 1'b1;
    end
    else
    begin
      boot_reg <= 1'b0;
    end
  end

  // Shadows freeze at reset and keep the last running values for a warm restart.
  always_ff @(posedge CLK_IN)
  begin
    if (rst_n && !boot_reg)
    begin
      pc_shadow_reg  <= pc_reg;
      psw_shadow_reg <= psw_reg;
    end
  end

  assign user        = psw_reg[`CRS_PSW_U];
  assign short_pairs = cfg_reg[`CRS_CFG_SR];
  assign in_handler  = (depth_reg != 4'h0);
  assign bus_wr      = REG_WR_IN && !(user && REG_ADDR_IN == `CRS_ADDR_USP);
  assign stack_op    = (OP_CODE_IN == OP_PUSH) || (OP_CODE_IN == OP_POP);
  assign sp_cur      = user ? usp_reg : {gpr_hi_reg[`CRS_SSP_HI], gpr_lo_reg[`CRS_SSP_LO]};
  assign push_addr   = sp_cur - `CRS_WORD_BYTES;
  assign stack_bad   = stack_op && user && (usp_reg > `CRS_USP_LIMIT);
  assign usp_illegal = user && ((OP_CODE_IN == OP_LOAD_USP) ||
                       ((REG_WR_IN || REG_RD_IN) && REG_ADDR_IN == `CRS_ADDR_USP));
  assign opa16       = OP_A_IN[15:0];
  assign opb16       = OP_B_IN[15:0];
  assign is_sub      = (OP_CODE_IN == OP_SUB);
  assign sum17       = is_sub ? ({1'b0, opb16} - {1'b0, opa16}) : ({1'b0, opb16} + {1'b0, opa16});
  assign ovf         = is_sub ? ((opb16[15] != opa16[15]) && (sum17[15] != opb16[15]))
                              : ((opb16[15] == opa16[15]) && (sum17[15] != opb16[15]));

  // General registers: bus writes first, so a same-cycle operation wins.
  always_ff @(posedge CLK_IN)
  begin
    if (rst_n)
    begin
      if (bus_wr && REG_ADDR_IN <= `CRS_ADDR_GPR_LAST)
      begin
        gpr_lo_reg[REG_ADDR_IN[3:0]] <= REG_WDATA_IN[15:0];
        if (REG_ADDR_IN[3:0] >= `CRS_FIRST_WIDE)
        begin
          gpr_hi_reg[REG_ADDR_IN[1:0]] <= REG_WDATA_IN[31:16];
        end
      end
      case (OP_CODE_IN)
        OP_ADD, OP_SUB: gpr_lo_reg[OP_REG_IN] <= sum17[15:0];
        OP_WR_WORD:     gpr_lo_reg[OP_REG_IN] <= opa16;
        OP_WR_BYTE:     gpr_lo_reg[OP_REG_IN][7:0] <= OP_A_IN[7:0];
        OP_WR_PAIR:
        begin
          gpr_lo_reg[OP_REG_IN] <= opa16;
          if (OP_REG_IN <= `CRS_LAST_NARROW || (short_pairs && OP_REG_IN <= `CRS_LAST_SHORT))
          begin
            gpr_lo_reg[OP_REG_IN + 4'h1] <= OP_A_IN[31:16];
          end
          else
          begin
            gpr_hi_reg[OP_REG_IN[1:0]] <= OP_A_IN[31:16];
          end
        end
        OP_PUSH:
        begin
          if (!user)
          begin
            {gpr_hi_reg[`CRS_SSP_HI], gpr_lo_reg[`CRS_SSP_LO]} <= push_addr;
          end
        end
        OP_POP:
        begin
          if (!user)
          begin
            {gpr_hi_reg[`CRS_SSP_HI], gpr_lo_reg[`CRS_SSP_LO]} <= sp_cur + `CRS_WORD_BYTES;
          end
        end
        default:
        begin
        end
      endcase
      if (boot_reg && warm_sync_reg)
      begin
        gpr_lo_reg[0] <= pc_shadow_reg[15:0];
        gpr_lo_reg[1] <= {8'h00, pc_shadow_reg[23:16]};
        gpr_lo_reg[2] <= psw_shadow_reg;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_reg <= PC_PRESET;
    end
    else if (OP_CODE_IN == OP_INSTR_START || OP_CODE_IN == OP_ENTER_USER)
    begin
      pc_reg <= OP_A_IN[23:0] & `CRS_PC_EVEN_MASK;
    end
    else if (REG_WR_IN && REG_ADDR_IN == `CRS_ADDR_PC)
    begin
      pc_reg <= REG_WDATA_IN[23:0] & `CRS_PC_EVEN_MASK;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      esp_reg <= 32'h0000_0000;
    end
    else if (OP_CODE_IN == OP_EXC_TAKE)
    begin
      esp_reg <= (esp_reg - `CRS_FRAME_BYTES) & `CRS_ESP_MASK;
    end
    else if (OP_CODE_IN == OP_EXC_RET)
    begin
      esp_reg <= (esp_reg + `CRS_FRAME_BYTES) & `CRS_ESP_MASK;
    end
    else if (REG_WR_IN && REG_ADDR_IN == `CRS_ADDR_ESP)
    begin
      esp_reg <= REG_WDATA_IN & `CRS_ESP_MASK;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      usp_reg <= 32'h0000_0000;
    end
    else if (user && stack_op && !stack_bad)
    begin
      usp_reg <= (OP_CODE_IN == OP_PUSH) ? push_addr : sp_cur + `CRS_WORD_BYTES;
    end
    else if (!user && OP_CODE_IN == OP_LOAD_USP)
    begin
      usp_reg <= OP_A_IN;
    end
    else if (bus_wr && REG_ADDR_IN == `CRS_ADDR_USP)
    begin
      usp_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      etb_reg <= 32'h0000_0000;
      cfg_reg <= 16'h0000;
    end
    else if (REG_WR_IN && REG_ADDR_IN == `CRS_ADDR_ETB)
    begin
      etb_reg <= REG_WDATA_IN;
    end
    else if (REG_WR_IN && REG_ADDR_IN == `CRS_ADDR_CFG)
    begin
      cfg_reg <= REG_WDATA_IN[15:0] & `CRS_CFG_MASK;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      depth_reg <= 4'h0;
    end
    else if (OP_CODE_IN == OP_EXC_TAKE && depth_reg != `CRS_DEPTH_MAX)
    begin
      depth_reg <= depth_reg + 4'h1;
    end
    else if (OP_CODE_IN == OP_EXC_RET && in_handler)
    begin
      depth_reg <= depth_reg - 4'h1;
    end
  end

  // Status word: a software write cannot set the user bit; an operation overrides.
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      psw_reg <= `CRS_PSW_RESET;
    end
    else
    begin
      if (REG_WR_IN && REG_ADDR_IN == `CRS_ADDR_PSW)
      begin
        psw_reg <= REG_WDATA_IN[15:0] & `CRS_PSW_MASK;
        psw_reg[`CRS_PSW_U] <= user;
      end
      case (OP_CODE_IN)
        OP_ADD, OP_SUB:
        begin
          psw_reg[`CRS_PSW_C] <= sum17[16];
          psw_reg[`CRS_PSW_F] <= ovf;
        end
        OP_CMP:
        begin
          psw_reg[`CRS_PSW_L] <= (opb16 < opa16);
          psw_reg[`CRS_PSW_N] <= ($signed(opb16) < $signed(opa16));
          psw_reg[`CRS_PSW_Z] <= (opb16 == opa16);
        end
        OP_INSTR_START: psw_reg[`CRS_PSW_P] <= psw_reg[`CRS_PSW_T] && !in_handler;
        OP_EXC_TAKE:
        begin
          psw_reg[`CRS_PSW_U] <= 1'b0;
          psw_reg[`CRS_PSW_P] <= 1'b0;
          if (OP_IRQ_IN)
          begin
            psw_reg[`CRS_PSW_I] <= 1'b0;
          end
        end
        OP_EXC_RET:
        begin
          psw_reg <= OP_B_IN[15:0] & `CRS_PSW_MASK;
          if (OP_IRQ_IN)
          begin
            psw_reg[`CRS_PSW_I] <= 1'b1;
          end
        end
        OP_ENTER_USER:  psw_reg[`CRS_PSW_U] <= 1'b1;
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      STEP_TRAP_OUT        <= 1'b0;
      ILLEGAL_OP_TRAP_OUT  <= 1'b0;
      BAD_ADDRESS_TRAP_OUT <= 1'b0;
      IRQ_ENABLE_OUT       <= 1'b0;
    end
    else
    begin
      STEP_TRAP_OUT        <= (OP_CODE_IN == OP_INSTR_END) && psw_reg[`CRS_PSW_P];
      ILLEGAL_OP_TRAP_OUT  <= usp_illegal;
      BAD_ADDRESS_TRAP_OUT <= stack_bad;
      IRQ_ENABLE_OUT       <= psw_reg[`CRS_PSW_E] && psw_reg[`CRS_PSW_I];
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      STACK_WR_OUT     <= 1'b0;
      STACK_RD_OUT     <= 1'b0;
      STACK_ADDR_OUT   <= 32'h0000_0000;
      STACK_WDATA_OUT  <= 32'h0000_0000;
      STACK_PSW_OUT    <= 16'h0000;
      HANDLER_ADDR_OUT <= 32'h0000_0000;
    end
    else
    begin
      STACK_WR_OUT <= ((OP_CODE_IN == OP_PUSH) && !stack_bad) || (OP_CODE_IN == OP_EXC_TAKE);
      STACK_RD_OUT <= ((OP_CODE_IN == OP_POP) && !stack_bad) || (OP_CODE_IN == OP_EXC_RET);
      case (OP_CODE_IN)
        OP_PUSH:
        begin
          STACK_ADDR_OUT  <= push_addr;
          STACK_WDATA_OUT <= {16'h0000, opa16};
        end
        OP_POP:      STACK_ADDR_OUT <= sp_cur;
        OP_EXC_TAKE:
        begin
          STACK_ADDR_OUT   <= (esp_reg - `CRS_FRAME_BYTES) & `CRS_ESP_MASK;
          STACK_WDATA_OUT  <= {8'h00, pc_reg};
          STACK_PSW_OUT    <= psw_reg;
          HANDLER_ADDR_OUT <= etb_reg + {22'h00_0000, OP_VECTOR_IN, 2'h0};
        end
        OP_EXC_RET:  STACK_ADDR_OUT <= esp_reg;
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PAIR_DATA_OUT <= 32'h0000_0000;
      REG_RDATA_OUT <= 32'h0000_0000;
      PC_OUT        <= PC_PRESET;
      PSW_OUT       <= `CRS_PSW_RESET;
    end
    else
    begin
      PC_OUT  <= pc_reg;
      PSW_OUT <= psw_reg;
      if (OP_CODE_IN == OP_RD_PAIR)
      begin
        PAIR_DATA_OUT <= pair_read(OP_REG_IN, short_pairs);
      end
      REG_RDATA_OUT <= 32'h0000_0000;
      if (REG_RD_IN)
      begin
        case (REG_ADDR_IN)
          `CRS_ADDR_PC:  REG_RDATA_OUT <= {8'h00, pc_reg};
          `CRS_ADDR_ESP: REG_RDATA_OUT <= esp_reg;
          `CRS_ADDR_USP: REG_RDATA_OUT <= user ? 32'h0000_0000 : usp_reg;
          `CRS_ADDR_ETB: REG_RDATA_OUT <= etb_reg;
          `CRS_ADDR_PSW: REG_RDATA_OUT <= {16'h0000, psw_reg};
          `CRS_ADDR_CFG: REG_RDATA_OUT <= {16'h0000, cfg_reg};
          default:
          begin
            if (REG_ADDR_IN <= `CRS_ADDR_GPR_LAST)
            begin
              REG_RDATA_OUT <= reg_full(REG_ADDR_IN[3:0]);
            end
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!rst_n);

  a_esp_clean_bits: assert property ((esp_reg & ~`CRS_ESP_MASK) == 32'h0)
    else $error("exception stack pointer has forbidden bits set");
  a_pc_even_addr: assert property (!pc_reg[0] && !PC_OUT[0])
    else $error("program counter is odd");
  a_reset_status: assert property (boot_reg |-> psw_reg == `CRS_PSW_RESET)
    else $error("status word wrong after reset");
  a_warm_pc_copy: assert property (boot_reg && warm_sync_reg |=>
    {gpr_lo_reg[1][7:0], gpr_lo_reg[0]} == $past(pc_shadow_reg))
    else $error("warm reset did not save program counter");
  a_user_entry_only: assert property ($rose(user) |->
    $past(OP_CODE_IN) == OP_ENTER_USER || $past(OP_CODE_IN) == OP_EXC_RET)
    else $error("user mode entered by other means");
  a_exc_supervisor: assert property (OP_CODE_IN == OP_EXC_TAKE |=> !user)
    else $error("handler not in supervisor mode");
  a_step_trap_pulse: assert property ((OP_CODE_IN == OP_INSTR_END && psw_reg[`CRS_PSW_P])
    |=> STEP_TRAP_OUT ##1 !STEP_TRAP_OUT || $past(OP_CODE_IN) == OP_INSTR_END)
    else $error("step trap not a pulse after pending end");
  a_trace_handler: assert property (OP_CODE_IN == OP_INSTR_START && in_handler
    |=> !psw_reg[`CRS_PSW_P])
    else $error("trace pending inside handler");
  a_bad_stack_addr: assert property (stack_bad |=> BAD_ADDRESS_TRAP_OUT && !STACK_WR_OUT
    && !STACK_RD_OUT && usp_reg == $past(usp_reg))
    else $error("bad user stack address not trapped");
  a_usp_user_guard: assert property (OP_CODE_IN == OP_LOAD_USP && user
    |=> ILLEGAL_OP_TRAP_OUT && usp_reg == $past(usp_reg))
    else $error("user stack pointer reached from user mode");
  a_cmp_zero_flag: assert property (OP_CODE_IN == OP_CMP |=>
    psw_reg[`CRS_PSW_Z] == ($past(OP_A_IN[15:0]) == $past(OP_B_IN[15:0])))
    else $error("zero flag wrong after compare");
  a_irq_global_off: assert property (OP_CODE_IN == OP_EXC_TAKE && OP_IRQ_IN
    |=> !psw_reg[`CRS_PSW_I] ##1 !IRQ_ENABLE_OUT)
    else $error("global enable not cleared on interrupt");
  a_exc_frame_push: assert property (OP_CODE_IN == OP_EXC_TAKE |=> STACK_WR_OUT &&
    esp_reg == (($past(esp_reg) - `CRS_FRAME_BYTES) & `CRS_ESP_MASK) && STACK_ADDR_OUT == esp_reg)
    else $error("exception frame not pushed");

endmodule
`default_nettype wire
